// >>> core/tone_pkg.sv
// Package with register map, field layout and timing constants of the tone generator.
package tone_pkg;
   // ----------------------------------------
   // Register indices and byte address width
   // ----------------------------------------
   localparam logic [7:0] IDX_RUN_KEYPAD = 8'hB4;
   localparam logic [7:0] IDX_LEVEL_SELECT = 8'hB5;
   localparam logic [7:0] IDX_REPEAT = 8'hB6;
   localparam logic [7:0] IDX_S1_LO = 8'hB7;
   localparam logic [7:0] IDX_S1_HI = 8'hB8;
   localparam logic [7:0] IDX_S2_LO = 8'hB9;
   localparam logic [7:0] IDX_S2_HI = 8'hBA;
   localparam logic [7:0] IDX_ON_DUR = 8'hBB;
   localparam logic [7:0] IDX_OFF_DUR = 8'hBC;
   localparam int ADDR_W = 12;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_RUN_KEYPAD = 8'h00;
   localparam logic [7:0] RST_LEVEL_SELECT = 8'h00;
   localparam logic [7:0] RST_REPEAT = 8'h00;
   localparam logic [7:0] RST_S1_LO = 8'h55;
   localparam logic [7:0] RST_S1_HI = 8'h15;
   localparam logic [7:0] RST_S2_LO = 8'h00;
   localparam logic [7:0] RST_S2_HI = 8'h40;
   localparam logic [7:0] RST_ON_DUR = 8'h02;
   localparam logic [7:0] RST_OFF_DUR = 8'h01;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RUN_BIT = 7;
   localparam int DUAL_TONE_BIT = 4;
   localparam int KEY_MSB = 3;
   localparam int GAIN_MSB = 7;
   localparam int GAIN_LSB = 4;
   localparam int SEL_MSB = 1;
   localparam int COUNT_MSB = 2;
   localparam int DUR_MSB = 5;
   // ----------------------------------------
   // Duration and repeat count encoding
   // ----------------------------------------
   localparam logic [5:0] DUR_FINE_LAST = 6'h14;
   localparam logic [5:0] DUR_COARSE_FIRST = 6'h19;
   localparam logic [5:0] DUR_COARSE_LAST = 6'h3C;
   localparam logic [5:0] DUR_CONTINUOUS = 6'h3F;
   localparam logic [2:0] COUNT_FOREVER = 3'h7;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int SAMPLE_HZ = 48_000;
   localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int FINE_STEP_MS = 10;
   localparam int COARSE_STEP_MS = 50;
   localparam int COARSE_BASE_MS = 250;
   localparam int MS_CYC = CLK_HZ / 1000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SEL_SUM = 2'b00,
      SEL_ONE = 2'b01,
      SEL_TWO = 2'b10,
      SEL_RAMP = 2'b11
   } sine_sel_t;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ON = 2'b01,
      PH_OFF = 2'b10
   } phase_t;
   typedef struct packed {
      logic valid;
      logic signed [15:0] sample;
   } audio_t;
endpackage : tone_pkg

// >>> core/tone_beep_generator.sv
// Tone and beep generator with AXI4-Lite register access.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tone_beep_generator #(
   parameter int MS_CYCLES = tone_pkg::MS_CYC,
   parameter int SAMPLE_CYCLES = tone_pkg::SAMPLE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [tone_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tone_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output tone_pkg::audio_t tone_out
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic run_r;
   logic dual_r;
   logic [3:0] key_r;
   logic [7:0] level_r;
   logic [2:0] count_r;
   logic [7:0] s1_lo_r, s1_hi_r, s2_lo_r, s2_hi_r;
   logic [5:0] on_r, off_r;
   localparam int ADDR_W_L = tone_pkg::ADDR_W;
   logic [ADDR_W_L-1:0] waddr_r;
   logic aw_have_r, w_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic done_pulse;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   wire logic do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   wire logic [9:0] widx = waddr_r[ADDR_W_L-1:2];
   wire logic wr_ok = (widx >= 10'(tone_pkg::IDX_RUN_KEYPAD))
      && (widx <= 10'(tone_pkg::IDX_OFF_DUR));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire logic wr_en = do_write && wr_ok && wstrb_r[0];
   wire logic [7:0] wb = wdata_r[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_r <= tone_pkg::RST_RUN_KEYPAD[tone_pkg::RUN_BIT];
         dual_r <= tone_pkg::RST_RUN_KEYPAD[tone_pkg::DUAL_TONE_BIT];
         key_r <= tone_pkg::RST_RUN_KEYPAD[tone_pkg::KEY_MSB:0];
         level_r <= tone_pkg::RST_LEVEL_SELECT;
         count_r <= tone_pkg::RST_REPEAT[tone_pkg::COUNT_MSB:0];
         s1_lo_r <= tone_pkg::RST_S1_LO;
         s1_hi_r <= tone_pkg::RST_S1_HI;
         s2_lo_r <= tone_pkg::RST_S2_LO;
         s2_hi_r <= tone_pkg::RST_S2_HI;
         on_r <= tone_pkg::RST_ON_DUR[tone_pkg::DUR_MSB:0];
         off_r <= tone_pkg::RST_OFF_DUR[tone_pkg::DUR_MSB:0];
      end else begin
         if (done_pulse) begin
            run_r <= 1'b0;
         end
         if (wr_en) begin
            unique case (widx[7:0])
               tone_pkg::IDX_RUN_KEYPAD: begin
                  run_r <= wb[tone_pkg::RUN_BIT];
                  dual_r <= wb[tone_pkg::DUAL_TONE_BIT];
                  key_r <= wb[tone_pkg::KEY_MSB:0];
               end
               tone_pkg::IDX_LEVEL_SELECT: level_r <= {wb[7:4], 2'b00, wb[1:0]};
               tone_pkg::IDX_REPEAT: count_r <= wb[tone_pkg::COUNT_MSB:0];
               tone_pkg::IDX_S1_LO: s1_lo_r <= wb;
               tone_pkg::IDX_S1_HI: s1_hi_r <= wb;
               tone_pkg::IDX_S2_LO: s2_lo_r <= wb;
               tone_pkg::IDX_S2_HI: s2_hi_r <= wb;
               tone_pkg::IDX_ON_DUR: on_r <= wb[tone_pkg::DUR_MSB:0];
               tone_pkg::IDX_OFF_DUR: off_r <= wb[tone_pkg::DUR_MSB:0];
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   wire logic [9:0] ridx = s_axi_araddr[ADDR_W_L-1:2];
   logic [7:0] rbyte;
   logic rd_ok;

   always_comb begin
      rbyte = 8'h00;
      rd_ok = 1'b1;
      unique case (ridx)
         10'(tone_pkg::IDX_RUN_KEYPAD): rbyte = {run_r, 2'b00, dual_r, key_r};
         10'(tone_pkg::IDX_LEVEL_SELECT): rbyte = level_r;
         10'(tone_pkg::IDX_REPEAT): rbyte = {5'h00, count_r};
         10'(tone_pkg::IDX_S1_LO): rbyte = s1_lo_r;
         10'(tone_pkg::IDX_S1_HI): rbyte = s1_hi_r;
         10'(tone_pkg::IDX_S2_LO): rbyte = s2_lo_r;
         10'(tone_pkg::IDX_S2_HI): rbyte = s2_hi_r;
         10'(tone_pkg::IDX_ON_DUR): rbyte = {2'b00, on_r};
         10'(tone_pkg::IDX_OFF_DUR): rbyte = {2'b00, off_r};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rbyte};
         s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sample tick and duration decode
   // ----------------------------------------
   logic [15:0] tick_cnt_r;
   wire logic tick = (tick_cnt_r == 16'(SAMPLE_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   // Reserved codes fall back to the shortest time so a cycle always ends.
   function automatic logic [11:0] dur_ms(input logic [5:0] code);
      if (code <= tone_pkg::DUR_FINE_LAST) begin
         dur_ms = 12'((int'(code) + 1) * tone_pkg::FINE_STEP_MS);
      end else if (code >= tone_pkg::DUR_COARSE_FIRST && code <= tone_pkg::DUR_COARSE_LAST) begin
         dur_ms = 12'(tone_pkg::COARSE_BASE_MS
            + (int'(code) - int'(tone_pkg::DUR_COARSE_FIRST)) * tone_pkg::COARSE_STEP_MS);
      end else begin
         dur_ms = 12'(tone_pkg::FINE_STEP_MS);
      end
   endfunction : dur_ms

   function automatic logic [5:0] cycles(input logic [2:0] c);
      unique case (c)
         3'h4: cycles = 6'd8;
         3'h5: cycles = 6'd16;
         3'h6: cycles = 6'd32;
         default: cycles = 6'(c) + 6'd1;
      endcase
   endfunction : cycles

   // ----------------------------------------
   // Beep sequencer
   // ----------------------------------------
   tone_pkg::phase_t phase_r;
   logic [16:0] ms_cnt_r;
   logic [11:0] ms_left_r;
   logic [5:0] beeps_r;
   wire logic ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));
   wire logic on_forever = (on_r == tone_pkg::DUR_CONTINUOUS);
   wire logic period_end = ms_tick && (ms_left_r == 12'd1);
   assign done_pulse = (phase_r == tone_pkg::PH_OFF) && period_end
      && (count_r != tone_pkg::COUNT_FOREVER) && (beeps_r == 6'd1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= tone_pkg::PH_IDLE;
         ms_cnt_r <= '0;
         ms_left_r <= 12'd0;
         beeps_r <= 6'd0;
      end else begin
         ms_cnt_r <= ms_tick ? 17'd0 : ms_cnt_r + 17'd1;
         if (ms_tick && ms_left_r != 12'd0) begin
            ms_left_r <= ms_left_r - 12'd1;
         end
         unique case (phase_r)
            tone_pkg::PH_IDLE: begin
               if (run_r) begin
                  phase_r <= tone_pkg::PH_ON;
                  ms_cnt_r <= '0;
                  ms_left_r <= dur_ms(on_r);
                  beeps_r <= cycles(count_r);
               end
            end
            tone_pkg::PH_ON: begin
               if (!run_r) begin
                  phase_r <= tone_pkg::PH_IDLE;
               end else if (period_end && !on_forever) begin
                  phase_r <= tone_pkg::PH_OFF;
                  ms_left_r <= dur_ms(off_r);
               end
            end
            tone_pkg::PH_OFF: begin
               if (!run_r || done_pulse) begin
                  phase_r <= tone_pkg::PH_IDLE;
               end else if (period_end) begin
                  phase_r <= tone_pkg::PH_ON;
                  ms_left_r <= dur_ms(on_r);
                  beeps_r <= beeps_r - 6'd1;
               end
            end
            default: phase_r <= tone_pkg::PH_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Sine generators
   // ----------------------------------------
   // Row and column steps for the keypad, 12 kHz base.
   function automatic logic [15:0] key_step(input logic [1:0] i, input logic col);
      logic [15:0] r;
      r = 16'h0000;
      if (!col) begin
         unique case (i)
            2'd0: r = 16'h0EDF;
            2'd1: r = 16'h1069;
            2'd2: r = 16'h122B;
            2'd3: r = 16'h1415;
         endcase
      end else begin
         unique case (i)
            2'd0: r = 16'h19C8;
            2'd1: r = 16'h1C86;
            2'd2: r = 16'h1F9B;
            2'd3: r = 16'h22EF;
         endcase
      end
      key_step = r;
   endfunction : key_step

   logic [1:0] row, col;
   always_comb begin
      unique case (key_r)
         4'h1: {row, col} = 4'b0000;
         4'h2: {row, col} = 4'b0001;
         4'h3: {row, col} = 4'b0010;
         4'hA: {row, col} = 4'b0011;
         4'h4: {row, col} = 4'b0100;
         4'h5: {row, col} = 4'b0101;
         4'h6: {row, col} = 4'b0110;
         4'hB: {row, col} = 4'b0111;
         4'h7: {row, col} = 4'b1000;
         4'h8: {row, col} = 4'b1001;
         4'h9: {row, col} = 4'b1010;
         4'hC: {row, col} = 4'b1011;
         4'hE: {row, col} = 4'b1100;
         4'h0: {row, col} = 4'b1101;
         4'hF: {row, col} = 4'b1110;
         default: {row, col} = 4'b1111;
      endcase
   end

   wire logic [15:0] step1 = dual_r ? key_step(row, 1'b0) : {s1_hi_r, s1_lo_r};
   wire logic [15:0] step2 = dual_r ? key_step(col, 1'b1) : {s2_hi_r, s2_lo_r};
   logic [15:0] acc1_r, acc2_r;
   wire logic active = (phase_r == tone_pkg::PH_ON);

   always_ff @(posedge aclk) begin
      if (!aresetn || phase_r == tone_pkg::PH_IDLE) begin
         acc1_r <= 16'h0000;
         acc2_r <= 16'h0000;
      end else if (tick) begin
         acc1_r <= acc1_r + step1 + 16'h0001;
         acc2_r <= acc2_r + step2 + 16'h0001;
      end
   end

   // Parabolic sine approximation keeps the block free of a ROM.
   function automatic logic signed [15:0] sine(input logic [15:0] ph);
      logic [14:0] x;
      logic [29:0] p;
      logic [15:0] m;
      x = ph[14:0];
      p = 30'(x) * 30'(15'h7FFF - x);
      m = 16'(p[29:13]);
      sine = ph[15] ? -$signed({1'b0, m[15:1]}) : $signed({1'b0, m[15:1]});
   endfunction : sine

   wire logic signed [15:0] w1 = sine(acc1_r);
   wire logic signed [15:0] w2 = sine(acc2_r);
   wire logic signed [15:0] c1 = sine(acc1_r + 16'h4000);
   logic signed [16:0] mix;

   always_comb begin
      unique case (tone_pkg::sine_sel_t'(level_r[tone_pkg::SEL_MSB:0]))
         tone_pkg::SEL_SUM: mix = (17'(w1) + 17'(w2)) >>> 1;
         tone_pkg::SEL_ONE: mix = 17'(w1);
         tone_pkg::SEL_TWO: mix = 17'(w2);
         default: mix = 17'sh03FFF - 17'(c1);
      endcase
   end

   function automatic logic [15:0] gain(input logic [3:0] g);
      unique case (g)
         4'h0: gain = 16'h7FFF;
         4'h1: gain = 16'h5FFC;
         4'h2: gain = 16'h4026;
         4'h3: gain = 16'h2FFE;
         4'h4: gain = 16'h2013;
         4'h5: gain = 16'h1800;
         4'h6: gain = 16'h100A;
         4'h7: gain = 16'h0C00;
         4'h8: gain = 16'h0805;
         4'h9: gain = 16'h0600;
         4'hA: gain = 16'h0402;
         4'hB: gain = 16'h0300;
         4'hC: gain = 16'h0201;
         4'hD: gain = 16'h0180;
         4'hE: gain = 16'h0101;
         default: gain = 16'h00C0;
      endcase
   endfunction : gain

   wire logic signed [33:0] scaled = 34'(mix) * $signed({2'b00, gain(level_r[7:4])});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tone_out <= '0;
      end else begin
         tone_out.valid <= tick;
         tone_out.sample <= active ? scaled[30:15] : 16'sh0000;
      end
   end
endmodule : tone_beep_generator
`default_nettype wire

// >>> sim/tone_sink.sv
// Model of the mixing path that listens to the tone stream.
`timescale 1ns/100ps
`default_nettype none
module tone_sink (
   input wire logic aclk,
   input wire logic clr,
   input wire tone_pkg::audio_t smp,
   output logic [15:0] loud,
   output logic [15:0] peak
);
   logic [15:0] mag;
   assign mag = smp.sample[15] ? 16'(-smp.sample) : 16'(smp.sample);
   // The mixer only takes a sample on its tick, so values between ticks are unseen.
   always_ff @(posedge aclk) begin
      if (clr) begin
         loud <= 16'h0000;
         peak <= 16'h0000;
      end else if (smp.valid && smp.sample != 16'sh0000) begin
         loud <= loud + 16'h0001;
         if (mag > peak) begin
            peak <= mag;
         end
      end
   end
endmodule : tone_sink
`default_nettype wire

// >>> sim/tone_chk.sv
// Checker of bus and stream timing at the tone generator ports.
`timescale 1ns/100ps
`default_nettype none
module tone_chk #(
   parameter int MS_CYCLES = 10,
   parameter int SAMPLE_CYCLES = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tone_pkg::audio_t tone_out
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   int gap;
   logic seen;
   logic rd_map;
   assign rd_map = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[11:2] >= 10'h0B4
      && s_axi_araddr[11:2] <= 10'h0BC;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (tone_out.valid) begin
         gap <= 1;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   chk_tick_gap: assert property (tone_out.valid && seen |-> gap == SAMPLE_CYCLES)
      else $error("sample ticks unevenly spaced");
   chk_tick_pulse: assert property (tone_out.valid |=> !tone_out.valid)
      else $error("sample tick longer than one cycle");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && s_axi_rresp == ($past(rd_map) ? 2'b00 : 2'b10)) else $error("read response wrong");
   chk_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   chk_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while response pending");
   chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   cov_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
   cov_tone: cover property (tone_out.valid && tone_out.sample != 16'sh0000);
endmodule : tone_chk
bind tone_beep_generator tone_chk #(.MS_CYCLES(MS_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .tone_out(tone_out));
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the tone and beep generator.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} row_t;
   typedef struct packed {logic [7:0] lv; logic [7:0] kp; logic [15:0] s1;
      logic [15:0] s2; logic ld;} tone_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic clr = 1'b1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] loud, peak;
   tone_pkg::audio_t tone_out;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int cn [7] = '{1, 2, 3, 4, 8, 16, 32};
   row_t rows [18] = '{'{1'b0, 8'hB4, 8'h00, 8'h00}, '{1'b0, 8'hB5, 8'h00, 8'h00},
      '{1'b0, 8'hB6, 8'h00, 8'h00}, '{1'b0, 8'hB7, 8'h00, 8'h55},
      '{1'b0, 8'hB8, 8'h00, 8'h15}, '{1'b0, 8'hB9, 8'h00, 8'h00},
      '{1'b0, 8'hBA, 8'h00, 8'h40}, '{1'b0, 8'hBB, 8'h00, 8'h02},
      '{1'b0, 8'hBC, 8'h00, 8'h01}, '{1'b1, 8'hB5, 8'hFF, 8'hF3},
      '{1'b1, 8'hB6, 8'h06, 8'h06}, '{1'b1, 8'hB7, 8'hA5, 8'hA5},
      '{1'b1, 8'hB8, 8'h5A, 8'h5A}, '{1'b1, 8'hB9, 8'h3C, 8'h3C},
      '{1'b1, 8'hBA, 8'hC3, 8'hC3}, '{1'b1, 8'hBB, 8'h3F, 8'h3F},
      '{1'b1, 8'hBC, 8'h3C, 8'h3C}, '{1'b1, 8'hB4, 8'h1F, 8'h1F}};
   // Step words.
   // A step of all ones adds zero per sample, so that generator stays silent.
   tone_row_t tn [10] = '{'{8'h00, 8'h00, 16'hFFFF, 16'hFFFF, 1'b0},
      '{8'h01, 8'h05, 16'hFFFF, 16'hFFFF, 1'b0}, '{8'h01, 8'h15, 16'hFFFF, 16'hFFFF, 1'b1},
      '{8'h01, 8'h00, 16'hFFFF, 16'h0554, 1'b0}, '{8'h01, 8'h00, 16'h0554, 16'hFFFF, 1'b1},
      '{8'h02, 8'h00, 16'h0554, 16'hFFFF, 1'b0}, '{8'h02, 8'h00, 16'hFFFF, 16'h05CD, 1'b1},
      '{8'h00, 8'h00, 16'hFFFF, 16'h0554, 1'b1}, '{8'h03, 8'h00, 16'h0554, 16'hFFFF, 1'b1},
      '{8'h03, 8'h00, 16'hFFFF, 16'hFFFF, 1'b0}};
   tone_beep_generator #(.MS_CYCLES(10), .SAMPLE_CYCLES(4)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tone_out(tone_out));
   tone_sink mix (.aclk(aclk), .clr(clr), .smp(tone_out), .loud(loud), .peak(peak));
   always #5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Handshakes are judged at the falling edge, where ready has long settled.
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
      output logic [1:0] r);
      logic ah, wh, bh;
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         r = bh ? bresp : 2'b11;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         n++;
      end while (!bh && n < 50);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = arvalid & arready;
         rh = rvalid;
         d = rdata;
         r = rh ? rresp : 2'b11;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         n++;
      end while (!rh && n < 50);
      rready <= 1'b0;
   endtask : rd
   task automatic regw(input logic [7:0] i, input logic [7:0] d);
      logic [1:0] r;
      wr({2'b00, i, 2'b00}, d, 4'hF, r);
      chk(32'(r), 32'h00000000);
   endtask : regw
   task automatic regr(input logic [7:0] i, output logic [7:0] d);
      logic [31:0] x;
      logic [1:0] r;
      rd({2'b00, i, 2'b00}, x, r);
      chk(32'(r), 32'h00000000);
      d = x[7:0];
   endtask : regr
   task automatic steps(input logic [15:0] s1, input logic [15:0] s2);
      regw(8'hB7, s1[7:0]);
      regw(8'hB8, s1[15:8]);
      regw(8'hB9, s2[7:0]);
      regw(8'hBA, s2[15:8]);
   endtask : steps
   task automatic run(input logic [7:0] kp, output int n);
      logic [7:0] v;
      int t0;
      t0 = cyc;
      clr <= 1'b1;
      regw(8'hB4, 8'h80 | kp);
      clr <= 1'b0;
      v = 8'h80;
      while (v[7] && cyc - t0 < 20000) regr(8'hB4, v);
      chk(32'(v[7]), 32'h00000000);
      n = cyc - t0;
   endtask : run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (60000) @(posedge aclk);
      err_total++;
      wrap_up();
   end
   initial begin
      int n, p0;
      logic [7:0] v;
      logic [1:0] r;
      logic [31:0] x;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k].wr) regw(rows[k].idx, rows[k].wd);
         regr(rows[k].idx, v);
         chk(32'(v), 32'(rows[k].ex));
      end
      $display("test registers done");
      wr(12'h2F4, 8'hFF, 4'hF, r);
      chk(32'(r), 32'h00000002);
      rd(12'h000, x, r);
      chk(32'(r), 32'h00000002);
      wr(12'h2DC, 8'h00, 4'h0, r);
      regr(8'hB7, v);
      chk(32'(v), 32'h000000A5);
      $display("test bus refusals done");
      regw(8'hB6, 8'h00);
      regw(8'hBB, 8'h00);
      regw(8'hBC, 8'h00);
      foreach (tn[k]) begin
         regw(8'hB5, tn[k].lv);
         steps(tn[k].s1, tn[k].s2);
         run(tn[k].kp, n);
         chk(32'(loud != 16'h0000), 32'(tn[k].ld));
      end
      for (int k = 0; k < 16; k++) begin
         run(8'h10 | 8'(k), n);
         chk(32'(loud != 16'h0000), 32'h00000001);
      end
      $display("test tone select done");
      regw(8'hB5, 8'h01);
      steps(16'h0554, 16'hFFFF);
      for (int k = 0; k < 7; k++) begin
         regw(8'hB6, 8'(k));
         run(8'h00, n);
         chk(32'(n >= cn[k] * 200 && n <= cn[k] * 200 + 40), 32'h00000001);
      end
      regw(8'hB6, 8'h00);
      clr <= 1'b1;
      regw(8'hB4, 8'h80);
      clr <= 1'b0;
      repeat (112) @(posedge aclk);
      n = loud;
      chk(32'(n > 0), 32'h00000001);
      repeat (70) @(posedge aclk);
      chk(32'(loud), 32'(n));
      repeat (60) @(posedge aclk);
      $display("test beep counts done");
      run(8'h00, n);
      p0 = peak;
      regw(8'hB5, 8'h21);
      run(8'h00, n);
      chk(32'(peak * 18 <= p0 * 10 && peak * 22 >= p0 * 10), 32'h00000001);
      regw(8'hB5, 8'hF1);
      run(8'h00, n);
      chk(32'(peak * 100 < p0 && peak * 250 > p0), 32'h00000001);
      $display("test gain done");
      regw(8'hB5, 8'h01);
      regw(8'hB6, 8'h07);
      regw(8'hB4, 8'h80);
      repeat (3000) @(posedge aclk);
      regr(8'hB4, v);
      chk(32'(v[7]), 32'h00000001);
      regw(8'hB4, 8'h00);
      clr <= 1'b1;
      repeat (2) @(posedge aclk);
      clr <= 1'b0;
      repeat (40) @(posedge aclk);
      chk(32'(loud), 32'h00000000);
      regw(8'hB6, 8'h00);
      regw(8'hBB, 8'h19);
      regw(8'hBC, 8'h3F);
      run(8'h00, n);
      chk(32'(n >= 2600 && n <= 2640), 32'h00000001);
      regw(8'hBB, 8'h3F);
      regw(8'hB4, 8'h80);
      repeat (1000) @(posedge aclk);
      regr(8'hB4, v);
      chk(32'(v[7]), 32'h00000001);
      $display("test continuous done");
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      regr(8'hB4, v);
      chk(32'(v), 32'h00000000);
      regr(8'hBB, v);
      chk(32'(v), 32'h00000002);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
